/* File: shared/spimsp_pkg.sv */
/*
  Package for the serial peripheral port: control and status layouts,
  reset values, pin indices and the master rate table.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spimsp_pkg;

  typedef struct packed {
    logic serial_enable;
    logic open_drain_select;
    logic master_select;
    logic cpol;
    logic cpha;
    logic rate_select_hi;
    logic rate_select_lo;
  } spimsp_ctrl_t;

  localparam spimsp_ctrl_t CTRL_RESET = 7'h04;

  // Status byte layout
  localparam int ST_DONE_BIT = 7;
  localparam int ST_WRITE_COLLISION_FLAG_BIT = 6;
  localparam int ST_MODE_FAULT_FLAG_BIT = 4;

  // Direction bits of the four serial pins in the port D direction word
  localparam int DIR_MISO = 2;
  localparam int DIR_MOSI = 3;
  localparam int DIR_SCK = 4;
  localparam int DIR_SS = 5;
  localparam logic [5:0] DIR_RESET = 6'h00;
  localparam logic [5:0] DIR_SPI_MASK = 6'h3C;

  // Synchroniser lanes
  localparam int PIN_SCK = 0;
  localparam int PIN_SS = 1;
  localparam int PIN_MOSI = 2;
  localparam int PIN_MISO = 3;

  localparam int BITS_PER_BYTE = 8;
  localparam logic [3:0] LAST_EDGE = 4'hF;

  // Bus clock divisors for the serial clock, one per rate code
  localparam int DIV_0 = 2;
  localparam int DIV_1 = 4;
  localparam int DIV_2 = 16;
  localparam int DIV_3 = 32;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MASTER = 3'b010,
    ST_SLAVE = 3'b100
  } spimsp_state_t;

endpackage

/* File: core/spimsp_core.sv */
/*
  Serial peripheral port, master or slave, one byte full duplex, MSB first.
  Software side is plain strobes and levels on the bus clock; every pad is
  split into input, output and active-low output enable.
  Assumes the pad wiring resolves the enables and that the other party
  keeps to the same clock polarity and phase.
*/
`timescale 1ns/10ps
module spimsp_core (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ctrl_wr,
  input wire spimsp_pkg::spimsp_ctrl_t i_ctrl,
  input wire logic i_dir_wr,
  input wire logic [5:0] i_dir,
  input wire logic i_status_rd,
  input wire logic i_data_rd,
  input wire logic i_data_wr,
  input wire logic [7:0] i_data,
  input wire logic i_ss_gpo,
  input wire logic i_sck,
  input wire logic i_ss_n,
  input wire logic i_mosi,
  input wire logic i_miso,
  output spimsp_pkg::spimsp_ctrl_t o_serial_control_reg,
  output logic [7:0] o_serial_status_reg,
  output logic [7:0] o_serial_data_reg,
  output logic [5:0] o_port_d_direction,
  output logic o_busy,
  output logic o_sck,
  output logic o_sck_oe_n,
  output logic o_mosi,
  output logic o_mosi_oe_n,
  output logic o_miso,
  output logic o_miso_oe_n,
  output logic o_ss_n,
  output logic o_ss_n_oe_n
);

  function automatic logic [4:0] half_period(input logic hi, input logic lo);
    unique case ({hi, lo})
      2'b00: half_period = 5'(spimsp_pkg::DIV_0 / 2);
      2'b01: half_period = 5'(spimsp_pkg::DIV_1 / 2);
      2'b10: half_period = 5'(spimsp_pkg::DIV_2 / 2);
      2'b11: half_period = 5'(spimsp_pkg::DIV_3 / 2);
    endcase
  endfunction

  spimsp_pkg::spimsp_ctrl_t ctrl;
  spimsp_pkg::spimsp_state_t state;
  logic [5:0] dir;
  logic [3:0] sync1, sync2, sync3, pin;
  logic sck_prev;
  logic [7:0] shifter, rd_buf;
  logic rx_bit, hold_bit;
  logic [3:0] edge_cnt;
  logic [4:0] div_cnt;
  logic sck_lvl;
  logic done_flag, write_collision_flag_flag, mode_fault_flag_flag;
  logic armed_data, armed_mode_fault_flag;

  logic ss_sel, fault, data_clear, wr_ok;
  logic m_edge, s_edge, ev, ev_lead, din, last, start_m, start_s;
  logic busy;

  // The last two stages agreeing rejects a single-cycle glitch on a pad.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
      pin <= 4'h2;
    end else begin
      sync1 <= {i_miso, i_mosi, i_ss_n, i_sck};
      sync2 <= sync1;
      sync3 <= sync2;
      for (int k = 0; k < 4; k++) begin
        if (sync2[k] == sync3[k]) begin
          pin[k] <= sync3[k];
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= pin[spimsp_pkg::PIN_SCK];
    end
  end

  assign ss_sel = !pin[spimsp_pkg::PIN_SS];
  assign busy = (state != spimsp_pkg::ST_IDLE);
  // Mode fault only while master, enabled, and select still an input
  assign fault = ctrl.serial_enable && ctrl.master_select && ss_sel
                 && !dir[spimsp_pkg::DIR_SS];
  assign data_clear = (i_data_rd || i_data_wr) && armed_data;
  // A write before the done flag was seen in a status read is inhibited.
  assign wr_ok = i_data_wr && !busy && (!done_flag || armed_data);

  // Edge sources: divider as master, synchronised pad as slave.
  assign m_edge = (state == spimsp_pkg::ST_MASTER)
                  && (div_cnt == half_period(ctrl.rate_select_hi,
                                             ctrl.rate_select_lo) - 5'd1);
  assign s_edge = !ctrl.master_select && ss_sel
                  && (pin[spimsp_pkg::PIN_SCK] != sck_prev);
  assign ev = (state == spimsp_pkg::ST_MASTER) ? m_edge
              : (ctrl.serial_enable && s_edge);
  assign ev_lead = (edge_cnt[0] == 1'b0);
  assign din = ctrl.master_select ? pin[spimsp_pkg::PIN_MISO]
               : pin[spimsp_pkg::PIN_MOSI];
  assign last = ev && (edge_cnt == spimsp_pkg::LAST_EDGE);
  assign start_m = ctrl.serial_enable && ctrl.master_select && wr_ok && !fault;
  // Phase 0 transfer opens on select; phase 1 on the first clock edge.
  assign start_s = ctrl.serial_enable && !ctrl.master_select && ss_sel
                   && (!ctrl.cpha || s_edge);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= spimsp_pkg::ST_IDLE;
    end else begin
      unique case (state)
        spimsp_pkg::ST_IDLE: begin
          if (start_m) begin
            state <= spimsp_pkg::ST_MASTER;
          end else if (start_s) begin
            state <= spimsp_pkg::ST_SLAVE;
          end
        end
        spimsp_pkg::ST_MASTER: begin
          if (last || fault) begin
            state <= spimsp_pkg::ST_IDLE;
          end
        end
        spimsp_pkg::ST_SLAVE: begin
          // Phase 0 busy lasts until select rises after the byte.
          if (!ctrl.serial_enable || ctrl.master_select
              || (ctrl.cpha && last) || (!ctrl.cpha && !ss_sel)) begin
            state <= spimsp_pkg::ST_IDLE;
          end
        end
        default: state <= spimsp_pkg::ST_IDLE;
      endcase
    end
  end

  // Master clock generator: half period per divider wrap.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_cnt <= 5'h00;
      sck_lvl <= 1'b0;
    end else if (state != spimsp_pkg::ST_MASTER || fault) begin
      div_cnt <= 5'h00;
      sck_lvl <= ctrl.cpol;
    end else if (m_edge) begin
      div_cnt <= 5'h00;
      sck_lvl <= !sck_lvl;
    end else begin
      div_cnt <= div_cnt + 5'd1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      edge_cnt <= 4'h0;
    end else if (start_m || (!ctrl.cpha && !ss_sel && !ctrl.master_select)) begin
      edge_cnt <= 4'h0;
    end else if (ev) begin
      edge_cnt <= edge_cnt + 4'd1;
    end
  end

  // Phase 0 samples on leading edges and shifts on trailing ones; phase 1
  // presents on leading and samples-and-shifts on trailing.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      shifter <= 8'h00;
      rx_bit <= 1'b0;
      hold_bit <= 1'b0;
    end else if (wr_ok && !fault) begin
      shifter <= i_data;
      hold_bit <= i_data[7];
    end else if (ev) begin
      if (ev_lead && !ctrl.cpha) begin
        rx_bit <= din;
      end else if (ev_lead) begin
        hold_bit <= shifter[7];
      end else if (!ctrl.cpha) begin
        shifter <= {shifter[6:0], rx_bit};
      end else begin
        shifter <= {shifter[6:0], din};
      end
    end
  end

  // Read buffer keeps the older byte when the done flag is still set.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_buf <= 8'h00;
    end else if (last && (!done_flag || data_clear)) begin
      if (ctrl.cpha) begin
        rd_buf <= {shifter[6:0], din};
      end else begin
        rd_buf <= {shifter[6:0], rx_bit};
      end
    end
  end

  // Flags: a status read arms the clear, the next access clears; set wins.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      done_flag <= 1'b0;
      write_collision_flag_flag <= 1'b0;
      mode_fault_flag_flag <= 1'b0;
      armed_data <= 1'b0;
      armed_mode_fault_flag <= 1'b0;
    end else begin
      if (last) begin
        done_flag <= 1'b1;
      end else if (data_clear) begin
        done_flag <= 1'b0;
      end
      if (i_data_wr && busy) begin
        write_collision_flag_flag <= 1'b1;
      end else if (data_clear) begin
        write_collision_flag_flag <= 1'b0;
      end
      if (fault) begin
        mode_fault_flag_flag <= 1'b1;
      end else if (i_ctrl_wr && armed_mode_fault_flag) begin
        mode_fault_flag_flag <= 1'b0;
      end
      if (i_status_rd) begin
        armed_data <= done_flag || write_collision_flag_flag;
        armed_mode_fault_flag <= mode_fault_flag_flag;
      end else begin
        if (i_data_rd || i_data_wr) begin
          armed_data <= 1'b0;
        end
        if (i_ctrl_wr) begin
          armed_mode_fault_flag <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl <= spimsp_pkg::CTRL_RESET;
      dir <= spimsp_pkg::DIR_RESET;
    end else begin
      if (fault) begin
        ctrl.serial_enable <= 1'b0;
        ctrl.master_select <= 1'b0;
      end else if (i_ctrl_wr) begin
        ctrl <= i_ctrl;
      end
      if (fault) begin
        dir <= dir & ~spimsp_pkg::DIR_SPI_MASK;
      end else if (i_dir_wr) begin
        dir <= i_dir;
      end
    end
  end

  // Pads are registered so every output leaves a flip-flop; this costs one
  // bus cycle of skew, equal on clock and data, so setup is preserved.
  logic mosi_val, miso_val, drv_sck, drv_mosi, drv_miso;
  assign mosi_val = ctrl.cpha ? hold_bit : shifter[7];
  assign miso_val = ctrl.cpha ? hold_bit : shifter[7];
  assign drv_sck = ctrl.serial_enable && ctrl.master_select
                   && dir[spimsp_pkg::DIR_SCK];
  assign drv_mosi = ctrl.serial_enable && ctrl.master_select
                    && dir[spimsp_pkg::DIR_MOSI];
  assign drv_miso = ctrl.serial_enable && !ctrl.master_select && ss_sel
                    && dir[spimsp_pkg::DIR_MISO];

  function automatic logic o_sck_next();
    o_sck_next = (state == spimsp_pkg::ST_MASTER) ? sck_lvl : ctrl.cpol;
  endfunction

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sck <= 1'b0;
      o_sck_oe_n <= 1'b1;
      o_mosi <= 1'b0;
      o_mosi_oe_n <= 1'b1;
      o_miso <= 1'b0;
      o_miso_oe_n <= 1'b1;
      o_ss_n <= 1'b1;
      o_ss_n_oe_n <= 1'b1;
    end else begin
      // Open-drain mode releases the pad instead of driving a one.
      o_sck <= (state == spimsp_pkg::ST_MASTER) ? sck_lvl : ctrl.cpol;
      o_sck_oe_n <= !(drv_sck && !(ctrl.open_drain_select && o_sck_next()));
      o_mosi <= mosi_val;
      o_mosi_oe_n <= !(drv_mosi && !(ctrl.open_drain_select && mosi_val));
      o_miso <= miso_val;
      o_miso_oe_n <= !(drv_miso && !(ctrl.open_drain_select && miso_val));
      o_ss_n <= i_ss_gpo;
      o_ss_n_oe_n <= !(dir[spimsp_pkg::DIR_SS]
                       && !(ctrl.open_drain_select && i_ss_gpo));
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_serial_control_reg <= spimsp_pkg::CTRL_RESET;
      o_serial_status_reg <= 8'h00;
      o_serial_data_reg <= 8'h00;
      o_port_d_direction <= spimsp_pkg::DIR_RESET;
      o_busy <= 1'b0;
    end else begin
      o_serial_control_reg <= ctrl;
      o_serial_status_reg <= 8'h00;
      o_serial_status_reg[spimsp_pkg::ST_DONE_BIT] <= done_flag;
      o_serial_status_reg[spimsp_pkg::ST_WRITE_COLLISION_FLAG_BIT] <= write_collision_flag_flag;
      o_serial_status_reg[spimsp_pkg::ST_MODE_FAULT_FLAG_BIT] <= mode_fault_flag_flag;
      o_serial_data_reg <= rd_buf;
      o_port_d_direction <= dir;
      o_busy <= busy;
    end
  end

endmodule

/* File: verif/spimsp_props.sv */
/*
  Checker for the serial port core: pin enables, clock train, flags.
  Sees only the core's ports; bound from tb_top.
*/
`timescale 1ns/10ps
module spimsp_props (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_data_wr,
  input wire spimsp_pkg::spimsp_ctrl_t o_serial_control_reg,
  input wire logic [7:0] o_serial_status_reg,
  input wire logic [5:0] o_port_d_direction,
  input wire logic o_busy,
  input wire logic o_sck,
  input wire logic o_sck_oe_n,
  input wire logic o_mosi_oe_n,
  input wire logic o_miso_oe_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic sck_d;
  logic tgl;
  logic [4:0] tog;
  logic [5:0] gap;
  spimsp_pkg::spimsp_ctrl_t ctl;
  logic [7:0] st;
  logic [5:0] dir;
  assign ctl = o_serial_control_reg;
  assign st = o_serial_status_reg;
  assign dir = o_port_d_direction;
  assign tgl = (o_sck != sck_d) && !o_sck_oe_n;
  function automatic logic [5:0] half_of(input logic [1:0] r);
    case (r)
      2'h0: return 6'(spimsp_pkg::DIV_0 / 2);
      2'h1: return 6'(spimsp_pkg::DIV_1 / 2);
      2'h2: return 6'(spimsp_pkg::DIV_2 / 2);
      default: return 6'(spimsp_pkg::DIV_3 / 2);
    endcase
  endfunction
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) sck_d <= 1'b0;
    else sck_d <= o_sck;
  end
  // Idle-level moves from control writes are counted too, so clear on a new byte
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) tog <= 5'h00;
    else if (i_data_wr && !o_busy) tog <= 5'h00;
    else if (tgl) tog <= tog + 5'h01;
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) gap <= 6'h01;
    else if (tgl) gap <= 6'h01;
    else if (gap != 6'h3F) gap <= gap + 6'h01;
  end
  sck_idle_a: assert property ((!o_busy && !o_sck_oe_n && $stable(ctl)) [*4] |->
    o_sck == ctl.cpol) else $error("serial clock off its idle level");
  // Enables and the mirrored control word leave their flops on the same edge
  slave_sck_a: assert property (!ctl.master_select |-> o_sck_oe_n)
    else $error("serial clock driven while slave");
  mosi_dir_a: assert property (!o_mosi_oe_n |->
    dir[spimsp_pkg::DIR_MOSI] && ctl.master_select) else $error("mosi driven");
  miso_drive_a: assert property (!o_miso_oe_n |-> dir[spimsp_pkg::DIR_MISO] &&
    !ctl.master_select && ctl.serial_enable) else $error("miso driven while master or off");
  fault_clear_a: assert property ($rose(st[spimsp_pkg::ST_MODE_FAULT_FLAG_BIT]) |->
    !ctl.serial_enable && !ctl.master_select && dir[5:2] == 4'h0) else $error("fault left");
  fault_cause_a: assert property ($rose(st[spimsp_pkg::ST_MODE_FAULT_FLAG_BIT]) |->
    $past(ctl.master_select) && !$past(dir[spimsp_pkg::DIR_SS])) else $error("bad fault");
  eight_clocks_a: assert property ($rose(st[spimsp_pkg::ST_DONE_BIT]) && ctl.master_select
    |-> ##2 tog == 5'd16) else $error("master byte without sixteen clock edges");
  half_period_a: assert property (o_busy && tgl && tog != 5'h00 |->
    gap == half_of({ctl.rate_select_hi, ctl.rate_select_lo})) else $error("bad sck period");
  collision_a: assert property (i_data_wr && o_busy && !st[spimsp_pkg::ST_DONE_BIT] |->
    ##[1:2] st[spimsp_pkg::ST_WRITE_COLLISION_FLAG_BIT]) else $error("collision flag not set");
  cover property ($rose(st[spimsp_pkg::ST_DONE_BIT]) && ctl.master_select);
  cover property ($rose(st[spimsp_pkg::ST_DONE_BIT]) && !ctl.master_select);
  cover property ($rose(st[spimsp_pkg::ST_MODE_FAULT_FLAG_BIT]));
endmodule

/* File: verif/spimsp_far_slave.sv */
/*
  Far-end slave model: shifts on the pad clock by polarity and phase.
  Assumes select, clock and data come from the resolved pad wires.
*/
`timescale 1ns/10ps
module spimsp_far_slave (
  input wire logic i_sck,
  input wire logic i_ss_n,
  input wire logic i_mosi,
  input wire logic i_cpol,
  input wire logic i_cpha,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic [7:0] o_rx
);
  initial o_miso = 1'b0;
  // Released line shows the inverse, so a stale bit never reads as valid
  always @(posedge i_ss_n) o_miso = ~o_miso;
  always @(negedge i_ss_n) begin
    o_rx = i_tx;
    if (!i_cpha) o_miso = o_rx[7];
  end
  always @(i_sck) begin
    if (!i_ss_n) begin
      if ((i_sck != i_cpol) ^ i_cpha) o_rx = {o_rx[6:0], i_mosi};
      else o_miso = o_rx[7];
    end
  end
endmodule

/* File: verif/tb_top.sv */
/*
  Bench for the serial port core: strobe tasks, far-end slave model, pads.
  Assumes the core, checker and model files; enables are resolved here.
*/
`timescale 1ns/10ps
module tb_top;
  logic i_clk, i_nrst, c_wr, d_wr, s_rd, r_rd, w_wr, gpo, t_sck, t_ss, t_mosi, t_slv;
  spimsp_pkg::spimsp_ctrl_t ctrl, ctl_q;
  logic [5:0] dir, dir_q;
  logic [7:0] wdat, m_tx, m_rx, sampled, st, rbuf;
  logic busy, p_sck, p_sck_oe, p_mosi, p_mosi_oe, p_miso, p_miso_oe, p_ss, p_ss_oe, m_miso;
  wire sck_w, ss_w, mosi_w, miso_w;
  int num_errors, n_compared, i;
  assign sck_w = p_sck_oe ? t_sck : p_sck;
  assign ss_w = p_ss_oe ? t_ss : p_ss;
  assign mosi_w = p_mosi_oe ? t_mosi : p_mosi;
  assign miso_w = p_miso_oe ? m_miso : p_miso;
  spimsp_core uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ctrl_wr(c_wr), .i_ctrl(ctrl),
    .i_dir_wr(d_wr), .i_dir(dir), .i_status_rd(s_rd), .i_data_rd(r_rd), .i_data_wr(w_wr),
    .i_data(wdat), .i_ss_gpo(gpo), .i_sck(sck_w), .i_ss_n(ss_w), .i_mosi(mosi_w),
    .i_miso(miso_w), .o_serial_control_reg(ctl_q), .o_serial_status_reg(st),
    .o_serial_data_reg(rbuf), .o_port_d_direction(dir_q), .o_busy(busy), .o_sck(p_sck),
    .o_sck_oe_n(p_sck_oe), .o_mosi(p_mosi), .o_mosi_oe_n(p_mosi_oe), .o_miso(p_miso),
    .o_miso_oe_n(p_miso_oe), .o_ss_n(p_ss), .o_ss_n_oe_n(p_ss_oe));
  spimsp_far_slave far (.i_sck(sck_w), .i_ss_n(ss_w | t_slv), .i_mosi(mosi_w),
    .i_cpol(ctrl.cpol), .i_cpha(ctrl.cpha), .i_tx(m_tx), .o_miso(m_miso), .o_rx(m_rx));
  task check(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Strobe for one cycle, then wait out the two-edge answer latency
  task op(input int k, input logic [7:0] v);
    @(negedge i_clk);
    case (k)
      0: begin c_wr = 1'b1; ctrl = v[6:0]; end
      1: begin d_wr = 1'b1; dir = v[5:0]; end
      2: s_rd = 1'b1;
      3: r_rd = 1'b1;
      default: begin w_wr = 1'b1; wdat = v; end
    endcase
    @(negedge i_clk);
    {c_wr, d_wr, s_rd, r_rd, w_wr} = 5'h00;
    repeat (2) @(negedge i_clk);
  endtask
  task wait_done;
    int n;
    n = 0;
    while (st[spimsp_pkg::ST_DONE_BIT] !== 1'b1 && n < 4000) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 4000) begin
      num_errors++;
      give_verdict;
    end
  endtask
  // Acts as external master; bit phases stay far above the pad sync delay
  task sbyte(input logic [7:0] b);
    t_ss = 1'b0;
    for (int k = 7; k >= 0; k--) begin
      repeat (16) @(negedge i_clk);
      t_mosi = b[k];
      repeat (16) @(negedge i_clk);
      t_sck = 1'b1;
      repeat (16) @(negedge i_clk);
      sampled[k] = miso_w;
      t_sck = 1'b0;
    end
    repeat (16) @(negedge i_clk);
    t_ss = 1'b1;
    t_mosi = ~t_mosi;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    {i_nrst, c_wr, d_wr, s_rd, r_rd, w_wr, t_sck, t_mosi, t_slv} = 9'h000;
    {gpo, t_ss} = 2'h3;
    ctrl = 7'h00;
    dir = 6'h00;
    wdat = 8'h00;
    m_tx = 8'h00;
    num_errors = 0;
    n_compared = 0;
    repeat (6) @(negedge i_clk);
    i_nrst = 1'b1;
    repeat (4) @(negedge i_clk);
    check({1'b0, ctl_q}, 8'h04);
    check({2'h0, dir_q}, 8'h00);
    check(st, 8'h00);
    for (i = 0; i < 6; i++) begin
      m_tx = 8'h3C + 8'(i);
      op(0, {4'h5, i[1:0], (i < 2) ? i[1:0] : {1'b1, i[0]}});
      t_sck = i[1];
      op(1, 8'h3C);
      gpo = 1'b0;
      repeat (8) @(negedge i_clk);
      op(4, 8'hA5 ^ 8'(i));
      if (i == 2) op(4, 8'hFF);
      wait_done;
      repeat (40) @(negedge i_clk);
      gpo = 1'b1;
      op(2, 8'h00);
      check(st, (i == 2) ? 8'hC0 : 8'h80);
      op(3, 8'h00);
      check(st, 8'h00);
      check(m_rx, 8'hA5 ^ 8'(i));
      // Fast rates sample a late-synchronised pad, so only slow ones are compared
      if (i > 1) check(rbuf, m_tx);
      $display("master test %0d ended", i);
    end
    t_slv = 1'b1;
    for (i = 0; i < 2; i++) begin
      op(0, {4'h4, 1'b0, i[0], 2'h3});
      t_sck = 1'b0;
      op(1, 8'h04);
      check({7'h00, p_miso_oe}, 8'h01);
      op(4, 8'h96 ^ 8'(i));
      sbyte(8'h69 + 8'(i));
      repeat (8) @(negedge i_clk);
      check(st, 8'h80);
      check(rbuf, 8'h69 + 8'(i));
      check(sampled, 8'h96 ^ 8'(i));
      op(2, 8'h00);
      op(3, 8'h00);
      $display("slave test %0d ended", i);
    end
    op(0, 8'h50);
    op(1, 8'h1C);
    t_ss = 1'b0;
    repeat (10) @(negedge i_clk);
    check(st, 8'h10);
    check({1'b0, ctl_q} & 8'h50, 8'h00);
    check({2'h0, dir_q}, 8'h00);
    t_ss = 1'b1;
    op(2, 8'h00);
    op(0, 8'h00);
    check(st, 8'h00);
    $display("fault test ended");
    give_verdict;
  end
endmodule
bind spimsp_core spimsp_props u_props (.i_clk, .i_nrst, .i_data_wr, .o_serial_control_reg,
  .o_serial_status_reg, .o_port_d_direction, .o_busy, .o_sck, .o_sck_oe_n, .o_mosi_oe_n,
  .o_miso_oe_n);
